// ---- verilog/art_timer.v ----
/*
  Top of the 12-bit autoreload PWM timer: APB byte-register slave,
  counter with reload and slow-mode prescaler, stop and capture logic,
  four PWM channels and the interrupt request levels.
  Assumes counter tick enables in the CLK domain; pins arrive asynchronously.
*/
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "art_defs.vh"

// Behaviour
// - Shared period is 4096 minus reload
// - Wrap reloads counter with reload value
// - Counter starts at zero, runs when clocked
// - Wrap loads duties, raises PWM outputs
// - Duty match drives PWM low
// - Polarity bit inverts, synced when armed
// - Output enable bit gives pin to PWM, except with the lite clock selected
// - Compare match sets flag except with the lite clock selected, may interrupt
// - Zero compare value never sets the compare flag
// - Enabled low stop pin sets stop
// - Software can set stop directly
// - Stop forces pattern, resets counter, values
// - Clearing stop returns pins to port
// - Capture edge latches counter, sets flag
// - Set capture flag blocks further captures
// - Capture read clears flag; writes ignored
// - Two-bit select picks counter clock
// - Slow divides by 32; halt stops, active halt too unless the lite clock runs with wrap irq
// - Wrap flag set, cleared by reading
// - Wrap vector separate; only wrap wakes
// - Arm bit gates shadow load, self clears
// - Channel status read clears compare flag
module art_timer (
  input  wire        CLK,
  input  wire        SYS_RST,
  input  wire [7:0]  PADDR,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        LT_TICK,
  input  wire        HF_TICK,
  input  wire        SLOW_MODE,
  input  wire        HALT_MODE,
  input  wire        ACTIVE_HALT,
  input  wire        STOP_N,
  input  wire        CAP_IN,
  output wire [3:0]  PWM_OUT,
  output wire [3:0]  PWM_OE_N,
  output reg         IRQ_CMP_CAP,
  output reg         IRQ_WRAP,
  output reg         WAKE_REQ
);

  reg  [11:0] cnt;
  reg  [11:0] reload_value;
  reg  [11:0] duty_pre [0:3];
  reg  [3:0]  inv_pre;
  reg  [3:0]  out_en;
  reg  [1:0]  clk_sel;
  reg         cap_ie;
  reg         wrap_ie;
  reg         cmp_ie;
  reg         wrap_flag;
  reg         cap_flag;
  reg  [11:0] cap_value;
  reg         stop_act;
  reg         stop_pin_en;
  reg  [3:0]  stop_pat;
  reg         arm;
  reg  [4:0]  prescale;
  reg         upd;
  reg         wrapped;
  reg  [3:0]  cnt_hi_latch;
  reg         cap_prev;
  reg         snap_cap;
  reg  [31:0] next_rdata;
  reg         next_err;
  reg         tick_src;
  wire        stop_sync;
  wire        cap_sync;
  wire [5:0]  idx;
  wire        setup;
  wire        acc;
  wire        wr;
  wire        rd;
  wire        run;
  wire        tick;
  wire        wrap_ev;
  wire        load;
  wire        pwm_ok;
  wire        cap_edge;
  wire [3:0]  cmp_flag;
  wire [3:0]  cmp_clr;
  wire [5:0]  ch_off;
  wire [5:0]  duty_off;
  wire [2:0]  wr_ch;
  wire [1:0]  duty_ch;
  wire        duty_hi;
  integer     i;

  assign idx   = PADDR[7:2];
  assign setup = PSEL & ~PENABLE;
  assign acc   = PSEL & PENABLE & PREADY;
  assign wr    = acc & PWRITE;
  assign rd    = acc & ~PWRITE;

  // Pins pass two flip-flops before any detection
  art_sync #(.RST_VAL(1'b1)) u_stop_sync (
    .clk  (CLK),
    .rst  (SYS_RST),
    .din  (STOP_N),
    .dout (stop_sync)
  );

  art_sync #(.RST_VAL(1'b0)) u_cap_sync (
    .clk  (CLK),
    .rst  (SYS_RST),
    .din  (CAP_IN),
    .dout (cap_sync)
  );

  // Counter clock source; CPU clock counts every cycle
  always @*
  begin
    case (clk_sel)
      `ART_CK_OFF:  tick_src = 1'b0;
      `ART_CK_LITE: tick_src = LT_TICK;
      `ART_CK_CPU:  tick_src = 1'b1;
      `ART_CK_FAST: tick_src = HF_TICK;
      default:      tick_src = 1'b0;
    endcase
  end

  // Halt stops; active-halt keeps only the lite tick with wrap irq
  assign run = ~HALT_MODE &
               (~ACTIVE_HALT | ((clk_sel == `ART_CK_LITE) & wrap_ie));

  // Slow mode counts 32 source ticks per counter tick
  always @(posedge CLK)
  begin
    if (SYS_RST | ~SLOW_MODE)
      prescale <= 5'h00;
    else if (run & tick_src)
      prescale <= prescale + 5'h01;
  end

  assign tick    = run & tick_src & (~SLOW_MODE | (prescale == `ART_PRE_TOP));
  assign wrap_ev = tick & (cnt == `ART_CNT_TOP);
  assign load    = wrap_ev & arm;
  assign pwm_ok  = (clk_sel != `ART_CK_LITE);

  // Upcounter; a wrap restarts from the reload value
  always @(posedge CLK)
  begin
    if (SYS_RST | stop_act)
      cnt <= `ART_CNT_RST;
    else if (wrap_ev)
      cnt <= reload_value;
    else if (tick)
      cnt <= cnt + 12'h001;
  end

  // Strobes tell channels the count just changed
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      upd     <= 1'b0;
      wrapped <= 1'b0;
    end
    else
    begin
      upd     <= tick & ~stop_act;
      wrapped <= wrap_ev & ~stop_act;
    end
  end

  // Arm bit: software write wins over hardware clear
  always @(posedge CLK)
  begin
    if (SYS_RST)
      arm <= `ART_SHD_RST;
    else if (wr & (idx == `ART_IDX_SHADOW))
      arm <= PWDATA[`ART_SHD_ARM];
    else if (load)
      arm <= 1'b0;
  end

  // Stop state; a pin or write set beats a software clear
  always @(posedge CLK)
  begin
    if (SYS_RST)
      stop_act <= 1'b0;
    else if (stop_pin_en & ~stop_sync)
      stop_act <= 1'b1;
    else if (wr & (idx == `ART_IDX_STOP))
      stop_act <= PWDATA[`ART_STOP_ACT];
  end

  // Offsets from the first index of each bank; duties take two bytes each
  assign ch_off   = idx - `ART_IDX_CHCS0;
  assign duty_off = idx - `ART_IDX_DUTY0H;
  assign wr_ch    = ch_off[2:0];
  assign duty_ch  = duty_off[2:1];
  assign duty_hi  = idx[0];

  // Software-written registers; stop clears the counting set
  always @(posedge CLK)
  begin
    if (SYS_RST | stop_act)
    begin
      reload_value <= `ART_CNT_RST;
      out_en       <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        duty_pre[i] <= `ART_CNT_RST;
    end
    else if (wr)
    begin
      if (idx == `ART_IDX_RELH)
        reload_value[11:8] <= PWDATA[3:0];
      if (idx == `ART_IDX_RELL)
        reload_value[7:0] <= PWDATA[7:0];
      if (idx == `ART_IDX_OUTEN)
        out_en <= {PWDATA[6], PWDATA[4], PWDATA[2], PWDATA[0]};
      if ((idx >= `ART_IDX_DUTY0H) && (idx <= `ART_IDX_DUTY3L))
      begin
        if (duty_hi)
          duty_pre[duty_ch][11:8] <= PWDATA[3:0];
        else
          duty_pre[duty_ch][7:0] <= PWDATA[7:0];
      end
    end
  end

  // Control fields that survive a stop
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      clk_sel     <= `ART_CK_OFF;
      cap_ie      <= 1'b0;
      wrap_ie     <= 1'b0;
      cmp_ie      <= 1'b0;
      inv_pre     <= 4'h0;
      stop_pin_en <= 1'b0;
      stop_pat    <= 4'h0;
    end
    else if (wr)
    begin
      if (idx == `ART_IDX_CSR)
      begin
        cap_ie  <= PWDATA[`ART_CSR_CAPIE];
        clk_sel <= PWDATA[`ART_CSR_CKH:`ART_CSR_CKL];
        wrap_ie <= PWDATA[`ART_CSR_WRAPIE];
        cmp_ie  <= PWDATA[`ART_CSR_COMPARE_IRQ_ENABLE];
      end
      if ((idx >= `ART_IDX_CHCS0) && (idx <= `ART_IDX_CHCS3))
        inv_pre[wr_ch[1:0]] <= PWDATA[`ART_CH_INV];
      if (idx == `ART_IDX_STOP)
      begin
        stop_pin_en <= PWDATA[`ART_STOP_PINEN];
        stop_pat    <= PWDATA[`ART_STOP_PAT_H:0];
      end
    end
  end

  // Wrap flag; clear only what the read reported
  always @(posedge CLK)
  begin
    if (SYS_RST)
      wrap_flag <= 1'b0;
    else if (wrap_ev & ~stop_act)
      wrap_flag <= 1'b1;
    else if (rd & (idx == `ART_IDX_CSR) & PRDATA[`ART_CSR_WRAPF])
      wrap_flag <= 1'b0;
  end

  assign cap_edge = cap_sync ^ cap_prev;

  // Capture on either edge, held until acknowledged
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      cap_prev  <= 1'b0;
      cap_flag  <= 1'b0;
      cap_value <= `ART_CNT_RST;
    end
    else
    begin
      cap_prev <= cap_sync;
      if (cap_edge & ~cap_flag)
      begin
        cap_value <= cnt;
        cap_flag  <= 1'b1;
      end
      else if (rd & snap_cap &
               ((idx == `ART_IDX_CAPH) || (idx == `ART_IDX_CAPL)))
        cap_flag <= 1'b0;
    end
  end

  // Per-channel compare clear comes from a reported flag
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_ch
      assign cmp_clr[g] = rd & (idx == (`ART_IDX_CHCS0 + g)) &
                          PRDATA[`ART_CH_COMPARE_MATCH_FLAG];
      art_channel u_ch (
        .clk      (CLK),
        .rst      (SYS_RST),
        .stop     (stop_act),
        .load     (load),
        .arm      (arm),
        .upd      (upd),
        .wrapped  (wrapped),
        .cnt      (cnt),
        .duty_pre (duty_pre[g]),
        .inv_pre  (inv_pre[g]),
        .pwm_ok   (pwm_ok),
        .en       (out_en[g]),
        .pat      (stop_pat[g]),
        .flag_clr (cmp_clr[g]),
        .pin      (PWM_OUT[g]),
        .oe_n     (PWM_OE_N[g]),
        .cmp_flag (cmp_flag[g])
      );
    end
  endgenerate

  // Read mux, sampled in the setup cycle
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (PADDR[1:0] != 2'b00)
      next_err = 1'b1;
    else if ((idx >= `ART_IDX_CHCS0) && (idx <= `ART_IDX_CHCS3))
      next_rdata[1:0] = {inv_pre[wr_ch[1:0]], cmp_flag[wr_ch[1:0]]};
    else if ((idx >= `ART_IDX_DUTY0H) && (idx <= `ART_IDX_DUTY3L))
      next_rdata[7:0] = duty_hi ? {4'h0, duty_pre[duty_ch][11:8]}
                                : duty_pre[duty_ch][7:0];
    else
    begin
      case (idx)
        `ART_IDX_CSR:    next_rdata[6:0] = {cap_flag, cap_ie, clk_sel,
                                            wrap_flag, wrap_ie, cmp_ie};
        `ART_IDX_CNTH:   next_rdata[3:0] = cnt_hi_latch;
        `ART_IDX_CNTL:   next_rdata[7:0] = cnt[7:0];
        `ART_IDX_RELH:   next_rdata[3:0] = reload_value[11:8];
        `ART_IDX_RELL:   next_rdata[7:0] = reload_value[7:0];
        `ART_IDX_OUTEN:  next_rdata[6:0] = {out_en[3], 1'b0, out_en[2], 1'b0,
                                            out_en[1], 1'b0, out_en[0]};
        `ART_IDX_CAPH:   next_rdata[3:0] = cap_value[11:8];
        `ART_IDX_CAPL:   next_rdata[7:0] = cap_value[7:0];
        `ART_IDX_STOP:   next_rdata[5:0] = {stop_act, stop_pin_en, stop_pat};
        `ART_IDX_SHADOW: next_rdata[0]   = arm;
        default:         next_err        = 1'b1;
      endcase
    end
  end

  // APB answer registered: ready in the first access cycle
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      PREADY       <= 1'b0;
      PRDATA       <= 32'h0000_0000;
      PSLVERR      <= 1'b0;
      snap_cap     <= 1'b0;
      cnt_hi_latch <= 4'h0;
    end
    else
    begin
      PREADY <= setup;
      if (setup)
      begin
        PRDATA   <= PWRITE ? 32'h0000_0000 : next_rdata;
        PSLVERR  <= next_err;
        snap_cap <= cap_flag;
        if (~PWRITE & (idx == `ART_IDX_CNTL))
          cnt_hi_latch <= cnt[11:8];
      end
      else
        PSLVERR <= 1'b0;
    end
  end

  // Interrupt request levels and active-halt wake
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      IRQ_CMP_CAP <= 1'b0;
      IRQ_WRAP    <= 1'b0;
      WAKE_REQ    <= 1'b0;
    end
    else
    begin
      IRQ_CMP_CAP <= (cmp_ie & (|cmp_flag)) | (cap_ie & cap_flag);
      IRQ_WRAP    <= wrap_ie & wrap_flag;
      WAKE_REQ    <= ACTIVE_HALT & wrap_ie & wrap_flag &
                     (clk_sel == `ART_CK_LITE);
    end
  end

endmodule // art_timer

`default_nettype wire

// ---- common/art_defs.vh ----
/*
  Constants of the autoreload PWM timer: register indices, field positions,
  reset values, counter limits and clock-select codes.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef ART_DEFS_VH
`define ART_DEFS_VH

// Register indices; the byte address on the bus is four times the index
`define ART_IDX_CSR      6'h0d
`define ART_IDX_CNTH     6'h0e
`define ART_IDX_CNTL     6'h0f
`define ART_IDX_RELH     6'h10
`define ART_IDX_RELL     6'h11
`define ART_IDX_OUTEN    6'h12
`define ART_IDX_CHCS0    6'h13
`define ART_IDX_CHCS3    6'h16
`define ART_IDX_DUTY0H   6'h17
`define ART_IDX_DUTY3L   6'h1e
`define ART_IDX_CAPH     6'h1f
`define ART_IDX_CAPL     6'h20
`define ART_IDX_STOP     6'h21
`define ART_IDX_SHADOW   6'h22

// Timer control-status fields
`define ART_CSR_CAPF     6
`define ART_CSR_CAPIE    5
`define ART_CSR_CKH      4
`define ART_CSR_CKL      3
`define ART_CSR_WRAPF    2
`define ART_CSR_WRAPIE   1
`define ART_CSR_COMPARE_IRQ_ENABLE    0

// Channel control-status fields
`define ART_CH_INV       1
`define ART_CH_COMPARE_MATCH_FLAG      0

// Stop control fields
`define ART_STOP_ACT     5
`define ART_STOP_PINEN   4
`define ART_STOP_PAT_H   3

// Shadow-load control field and its reset value
`define ART_SHD_ARM      0
`define ART_SHD_RST      1'b1

// Counter clock select codes
`define ART_CK_OFF       2'b00
`define ART_CK_LITE      2'b01
`define ART_CK_CPU       2'b10
`define ART_CK_FAST      2'b11

// Counter limits and slow-mode divide
`define ART_CNT_TOP      12'hfff
`define ART_CNT_RST      12'h000
`define ART_PRE_TOP      5'h1f

`endif

// ---- verilog/art_sync.v ----
/*
  Two-stage synchroniser for one asynchronous pin.
  Assumes a single clock with synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module art_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);

  reg stage1;

  // First stage feeds only the second one
  always @(posedge clk)
  begin
    if (rst)
    begin
      stage1 <= RST_VAL;
      dout   <= RST_VAL;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // art_sync

`default_nettype wire

// ---- verilog/art_channel.v ----
/*
  One PWM channel: active duty and polarity copies, raw waveform,
  compare flag and the pin drive with its output enable.
  Assumes counter update strobes from the timer core on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "art_defs.vh"

module art_channel (
  input  wire        clk,
  input  wire        rst,
  input  wire        stop,
  input  wire        load,
  input  wire        arm,
  input  wire        upd,
  input  wire        wrapped,
  input  wire [11:0] cnt,
  input  wire [11:0] duty_pre,
  input  wire        inv_pre,
  input  wire        pwm_ok,
  input  wire        en,
  input  wire        pat,
  input  wire        flag_clr,
  output reg         pin,
  output reg         oe_n,
  output reg         cmp_flag
);

  reg  [11:0] duty_act;
  reg         inv_act;
  reg         raw;
  wire        match;

  assign match = upd & (cnt == duty_act);

  // Active duty copy, cleared while stopped
  always @(posedge clk)
  begin
    if (rst | stop)
      duty_act <= `ART_CNT_RST;
    else if (load)
      duty_act <= duty_pre;
  end

  // Polarity follows the wrap while armed, at once otherwise
  always @(posedge clk)
  begin
    if (rst)
      inv_act <= 1'b0;
    else if (load | ~arm)
      inv_act <= inv_pre;
  end

  // Match drops the waveform, a wrap raises it
  always @(posedge clk)
  begin
    if (rst | stop)
      raw <= 1'b0;
    else if (match)
      raw <= 1'b0;
    else if (upd & wrapped)
      raw <= 1'b1;
  end

  // Compare flag; a new match beats a read clear
  always @(posedge clk)
  begin
    if (rst)
      cmp_flag <= 1'b0;
    else if (match & (duty_act != `ART_CNT_RST) & pwm_ok)
      cmp_flag <= 1'b1;
    else if (flag_clr)
      cmp_flag <= 1'b0;
  end

  // Stop pattern goes after the inverter
  always @(posedge clk)
  begin
    if (rst)
    begin
      pin  <= 1'b0;
      oe_n <= 1'b1;
    end
    else if (stop)
    begin
      pin  <= pat;
      oe_n <= 1'b0;
    end
    else
    begin
      pin  <= raw ^ inv_act;
      oe_n <= ~(en & pwm_ok);
    end
  end

endmodule // art_channel

`default_nettype wire

// ---- bench/art_timer_monitor.sv ----
/*
  Checker for art_timer: bus answer timing, error decode, stop drive and
  interrupt clear causes.
  Assumes it is bound to art_timer; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "art_defs.vh"
module art_timer_monitor (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic [7:0]  PADDR,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        ACTIVE_HALT,
  input wire logic [3:0]  PWM_OUT,
  input wire logic [3:0]  PWM_OE_N,
  input wire logic        IRQ_CMP_CAP,
  input wire logic        IRQ_WRAP,
  input wire logic        WAKE_REQ
);
  // Decoded accesses; a flag clear reaches the irq flop up to three edges later
  wire [5:0] idx = PADDR[7:2];
  wire [3:0] pat = PWDATA[3:0];
  wire       acc = PSEL && PENABLE && PREADY;
  wire       bad = (idx < `ART_IDX_CSR) || (idx > `ART_IDX_SHADOW) || (PADDR[1:0] != 2'b00);
  wire       csr = acc && ((idx == `ART_IDX_CSR) || (idx == `ART_IDX_STOP));
  wire       chs = (idx >= `ART_IDX_CHCS0) && (idx <= `ART_IDX_CHCS3);
  wire       clr = csr || (acc && (chs || (idx == `ART_IDX_CAPH) || (idx == `ART_IDX_CAPL)));
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  chk_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_err_decode: assert property (PREADY |-> PSLVERR == bad)
    else $error("error flag disagrees with address");
  chk_err_nodata: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error answer carries data");
  chk_byte_data: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_stop_force: assert property (acc && PWRITE && idx == `ART_IDX_STOP && PWDATA[5]
    |-> ##2 (PWM_OE_N == 4'h0 && PWM_OUT == $past(pat, 2)))
    else $error("stop pattern not driven");
  chk_wrap_clear: assert property ($fell(IRQ_WRAP)
    |-> $past(csr, 1) || $past(csr, 2) || $past(csr, 3))
    else $error("wrap request dropped without status access");
  chk_cmp_clear: assert property ($fell(IRQ_CMP_CAP)
    |-> $past(clr, 1) || $past(clr, 2) || $past(clr, 3))
    else $error("compare request dropped without read");
  chk_wake_gate: assert property (!ACTIVE_HALT ##1 !ACTIVE_HALT |-> !WAKE_REQ)
    else $error("wake outside active halt");
endmodule // art_timer_monitor
bind art_timer art_timer_monitor art_timer_monitor_inst (.CLK(CLK), .SYS_RST(SYS_RST),
  .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ACTIVE_HALT(ACTIVE_HALT),
  .PWM_OUT(PWM_OUT), .PWM_OE_N(PWM_OE_N), .IRQ_CMP_CAP(IRQ_CMP_CAP),
  .IRQ_WRAP(IRQ_WRAP), .WAKE_REQ(WAKE_REQ));
`default_nettype wire

// ---- bench/art_power_stage.sv ----
/*
  Power stage model: watches PWM channel 0 and drives the stop and capture pins.
  Assumes the bench clock; a released PWM pin reads low through a pull-down.
*/
`timescale 1ns/1ps
`default_nettype none
module art_power_stage (
  input  wire logic       clk,
  input  wire logic [3:0] pwm,
  input  wire logic [3:0] pwm_oe_n,
  input  wire logic       fault,
  input  wire logic       cap_tgl,
  output var  logic       stop_n,
  output var  logic       cap_pin,
  output var  int         period,
  output var  int         high_time
);
  int   cnt = 0;
  int   hc = 0;
  logic prev = 1'b0;
  // Released pin reads low, so a stale drive never counts as high
  wire  lvl = pwm_oe_n[0] ? 1'b0 : pwm[0];
  // Stop pin idles high, pulled low on a converter fault
  assign stop_n = ~fault;
  initial cap_pin = 1'b0;
  // Period and high time close at every rising edge of the pin
  always @(posedge clk)
  begin
    prev <= lvl;
    cnt  <= cnt + 1;
    hc   <= hc + (lvl ? 1 : 0);
    if (lvl && !prev)
    begin
      period    <= cnt;
      high_time <= hc;
      cnt       <= 1;
      hc        <= 1;
    end
    if (cap_tgl)
      cap_pin <= ~cap_pin;
  end
endmodule // art_power_stage
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for art_timer: APB master tasks, integer model of
  period and duty, capture, halt and stop checks.
  Assumes a 10 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "art_defs.vh"
module tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        halt = 1'b0;
  logic        fault = 1'b0;
  logic        cap_tgl = 1'b0;
  logic        lt_tick = 1'b0;
  logic        slow = 1'b0;
  logic        ahalt = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, stop_n, cap_in, irq_cc, irq_wrap;
  wire  [3:0]  pwm_out, pwm_oe_n;
  int          period, high_time, rel, duty, inv, c1, c2, wf;
  int          miscompares = 0;
  int          compares = 0;
  logic [31:0] rd;
  logic        err;

  always #50 clk = ~clk;

  art_timer art_timer_inst (.CLK(clk), .SYS_RST(sys_rst), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LT_TICK(lt_tick), .HF_TICK(1'b0), .SLOW_MODE(slow), .HALT_MODE(halt),
    .ACTIVE_HALT(ahalt), .STOP_N(stop_n), .CAP_IN(cap_in), .PWM_OUT(pwm_out),
    .PWM_OE_N(pwm_oe_n), .IRQ_CMP_CAP(irq_cc), .IRQ_WRAP(irq_wrap), .WAKE_REQ());
  art_power_stage art_power_stage_inst (.clk(clk), .pwm(pwm_out), .pwm_oe_n(pwm_oe_n),
    .fault(fault), .cap_tgl(cap_tgl), .stop_n(stop_n), .cap_pin(cap_in),
    .period(period), .high_time(high_time));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer, held until pready is seen high at a rising edge
  task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
      miscompares++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask

  task wr(input logic [5:0] idx, input int d);
    apb(1'b1, idx, 32'(d));
    chk({31'h0, err}, 32'h0);
  endtask

  // Low byte first, so the high nibble comes from the same snapshot
  task rdcnt(output int v);
    apb(1'b0, `ART_IDX_CNTL, 32'h0);
    v = int'(rd[7:0]);
    apb(1'b0, `ART_IDX_CNTH, 32'h0);
    v = v + int'(rd[3:0]) * 256;
  endtask

  // One edge on the capture pin, then time for the synchroniser
  task pulse_cap;
    @(posedge clk);
    cap_tgl <= 1'b1;
    @(posedge clk);
    cap_tgl <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task final_report;
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog well beyond the expected run of some 5000 cycles
  initial
  begin
    #2000000;
    miscompares++;
    final_report;
  end

  initial
  begin
    void'($urandom(32'h29d09f24));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(`ART_IDX_CSR, 32'h0);
    rdc(`ART_IDX_SHADOW, 32'h1);
    rdc(`ART_IDX_OUTEN, 32'h0);
    rdc(`ART_IDX_CNTL, 32'h0);
    apb(1'b0, 6'h3f, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Reload stays below every duty so a waveform appears
    rel = 'hff0;
    wr(`ART_IDX_RELH, rel >> 8);
    wr(`ART_IDX_RELL, rel & 255);
    duty = 'hff8;
    inv = 0;
    for (int k = 0; k < 5; k++)
    begin
      if (k > 0)
      begin
        duty = rel + 1 + int'($urandom % 14);
        inv = int'($urandom % 2);
      end
      wr(`ART_IDX_DUTY0H, duty >> 8);
      wr(`ART_IDX_DUTY0H + 6'h1, duty & 255);
      wr(`ART_IDX_CHCS0, inv * 2);
      wr(`ART_IDX_SHADOW, 1);
      if (k == 0)
      begin
        wr(`ART_IDX_OUTEN, 'h01);
        wr(`ART_IDX_CSR, 'h13);
        repeat (4096) @(posedge clk);
      end
      repeat (64) @(posedge clk);
      chk(period, 4096 - rel);
      chk(high_time, inv ? 4096 - duty : duty - rel);
      rdc(`ART_IDX_SHADOW, 32'h0);
    end
    // Halt freezes the count, so flags and capture become predictable
    halt <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, irq_cc}, 32'h1);
    rdc(`ART_IDX_CHCS0, 32'(inv * 2 + 1));
    rdc(`ART_IDX_CHCS0, 32'(inv * 2));
    rdc(`ART_IDX_CHCS0 + 6'h1, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_cc}, 32'h0);
    chk({31'h0, irq_wrap}, 32'h1);
    rdc(`ART_IDX_CSR, 32'h17);
    rdc(`ART_IDX_CSR, 32'h13);
    rdcnt(c1);
    repeat (10) @(posedge clk);
    rdcnt(c2);
    chk(32'(c2), 32'(c1));
    pulse_cap;
    halt <= 1'b0;
    repeat (5) @(posedge clk);
    halt <= 1'b1;
    pulse_cap;
    rdcnt(c2);
    wf = (c2 < c1) ? 4 : 0;
    rdc(`ART_IDX_CSR, 32'('h53 | wf));
    rdc(`ART_IDX_CAPL, 32'(c1 & 255));
    rdc(`ART_IDX_CAPH, 32'(c1 >> 8));
    wr(`ART_IDX_CSR, 'h52);
    rdc(`ART_IDX_CSR, 32'h12);
    // Stop from the pin, then from software
    wr(`ART_IDX_OUTEN, 'h55);
    wr(`ART_IDX_STOP, 'h1a);
    fault <= 1'b1;
    repeat (8) @(posedge clk);
    chk({28'h0, pwm_out}, 32'ha);
    chk({28'h0, pwm_oe_n}, 32'h0);
    rdc(`ART_IDX_STOP, 32'h3a);
    rdc(`ART_IDX_RELL, 32'h0);
    rdc(`ART_IDX_OUTEN, 32'h0);
    rdc(`ART_IDX_DUTY0H + 6'h1, 32'h0);
    rdc(`ART_IDX_CNTL, 32'h0);
    fault <= 1'b0;
    repeat (4) @(posedge clk);
    wr(`ART_IDX_STOP, 'h0a);
    repeat (3) @(posedge clk);
    chk({28'h0, pwm_oe_n}, 32'hf);
    wr(`ART_IDX_STOP, 'h25);
    repeat (3) @(posedge clk);
    chk({28'h0, pwm_out}, 32'h5);
    chk({28'h0, pwm_oe_n}, 32'h0);
    wr(`ART_IDX_STOP, 0);
    // Lite tick under active halt keeps counting; pins stay with the port
    wr(`ART_IDX_CSR, 'h0a);
    wr(`ART_IDX_OUTEN, 'h01);
    halt <= 1'b0;
    ahalt <= 1'b1;
    wf = 0;
    repeat (40)
    begin
      @(posedge clk);
      duty = int'($urandom % 2);
      lt_tick <= duty[0];
      wf = wf + duty;
    end
    @(posedge clk);
    lt_tick <= 1'b0;
    rdcnt(c2);
    chk(32'(c2), 32'(wf));
    chk({28'h0, pwm_oe_n}, 32'hf);
    // CPU clock is frozen by active halt, then slow mode counts every 32nd cycle
    wr(`ART_IDX_CSR, 'h12);
    repeat (20) @(posedge clk);
    ahalt <= 1'b0;
    slow <= 1'b1;
    repeat (320) @(posedge clk);
    halt <= 1'b1;
    slow <= 1'b0;
    rdcnt(c1);
    chk(32'(c1), 32'(wf + 10));
    final_report;
  end
endmodule // tb_top
`default_nettype wire
